// ---- lsm_defs.svh ----
// Register offsets, field positions, reset values and timing counts of the light measure control
`ifndef LSM_DEFS_SVH
`define LSM_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define LSM_OFS_ENABLE 8'h00
`define LSM_OFS_INTEG 8'h01
`define LSM_OFS_WAIT 8'h03
`define LSM_OFS_LOWLO 8'h04
`define LSM_OFS_LOWHI 8'h05
`define LSM_OFS_HIGHLO 8'h06
`define LSM_OFS_HIGHHI 8'h07
`define LSM_OFS_FILTER 8'h0c
`define LSM_OFS_CONFIG 8'h0d
`define LSM_OFS_STATUS 8'h13

// ****************************************
// Field positions
// ****************************************
`define LSM_EN_OSC 0
`define LSM_EN_MEAS 1
`define LSM_EN_WAIT 3
`define LSM_EN_MASK 4
`define LSM_EN_SLEEP 6
`define LSM_CFG_X12 1
`define LSM_ST_VALID 0
`define LSM_ST_IRQ 4

// ****************************************
// Reset values and commands
// ****************************************
`define LSM_RST_ENABLE 8'h00
`define LSM_RST_INTEG 8'hff
`define LSM_RST_WAIT 8'hff
`define LSM_RST_LIMIT 8'h00
`define LSM_RST_FILTER 8'h00
`define LSM_RST_CONFIG 8'h00
`define LSM_CMD_IRQ_CLEAR 5'h06

// ****************************************
// Timing
// ****************************************
`define LSM_STEP_NS 2730
`define LSM_CLK_NS 10
`define LSM_STEP_CYCLES (`LSM_STEP_NS / `LSM_CLK_NS)
`define LSM_LONG_FACTOR 12

`endif

// ---- lsm_pkg.sv ----
// Types of the light measure control
package lsm_pkg;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_INTEG,
    PH_WAIT
  } lsm_phase_type;

  typedef struct packed {
    logic [7:0] enableReg;
    logic [7:0] integReg;
    logic [7:0] waitReg;
    logic [15:0] lowLimit;
    logic [15:0] highLimit;
    logic [7:0] filterReg;
    logic [7:0] configReg;
    lsm_phase_type phase;
    logic [18:0] tick;
    logic [8:0] steps;
    logic [5:0] outCount;
    logic irqFlag;
    logic validFlag;
    logic intOe;
    logic [7:0] readData;
    logic measureStart;
  } lsm_state_type;

endpackage : lsm_pkg

// ---- lsm_light_measure_control.sv ----
// Measurement cycle, window comparator, persistence filter and registers of the light sensor
// ****************************************
// ****************************************
`timescale 1ns/1ps
`default_nettype none
`include "lsm_defs.svh"

module lsm_light_measure_control (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register write port from the serial command engine
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWriteData,
  // Special function strobe with its code
  input wire logic specialCmd,
  input wire logic [4:0] specialCode,
  // Register read port
  input wire logic [7:0] readAddr,
  output logic [7:0] regReadData,
  // Channel 0 result from the converter
  input wire logic [15:0] channel0Result,
  // Converter control
  output logic converterRun,
  output logic measureStart,
  // Open-drain interrupt pin, low when driven
  input wire logic intIn,
  output logic intOut,
  output logic intOe
);

  // ****************************************
  // Helper functions
  // ****************************************

  // Persistence code to required out-of-range count
  function automatic logic [5:0] filterNeeded(input logic [3:0] code);
    logic [5:0] res;
    res = 6'h00;
    if (code <= 4'h3) begin
      res = {2'b00, code};
    end else begin
      res = 6'(({2'b00, code} - 6'h03) * 6'h05);
    end
    return res;
  endfunction : filterNeeded

  // Phase length in steps: 256 minus the register value
  function automatic logic [8:0] stepCount(input logic [7:0] value);
    return 9'h100 - {1'b0, value};
  endfunction : stepCount

  localparam logic [18:0] STEP_TICKS = 19'(`LSM_STEP_CYCLES);
  localparam logic [18:0] LONG_TICKS = 19'(`LSM_STEP_CYCLES * `LSM_LONG_FACTOR);

  lsm_pkg::lsm_state_type st;
  lsm_pkg::lsm_state_type next_st;

  // ****************************************
  // Next state
  // ****************************************

  // Registers, phase sequencer and interrupt logic
  always_comb begin
    logic outside;
    logic stepDone;
    logic integEnd;
    logic raiseIrq;
    logic [5:0] needed;
    logic [18:0] stepTicks;
    logic [5:0] cnt;
    outside = 1'b0;
    stepDone = 1'b0;
    integEnd = 1'b0;
    raiseIrq = 1'b0;
    needed = filterNeeded(st.filterReg[3:0]);
    stepTicks = STEP_TICKS;
    cnt = st.outCount;
    next_st = st;
    next_st.measureStart = 1'b0;

    // Register writes; reserved enable bits kept as written by host
    if (regWrite) begin
      case (regAddr)
        `LSM_OFS_ENABLE: next_st.enableReg = regWriteData;
        `LSM_OFS_INTEG: next_st.integReg = regWriteData;
        `LSM_OFS_WAIT: next_st.waitReg = regWriteData;
        `LSM_OFS_LOWLO: next_st.lowLimit[7:0] = regWriteData;
        `LSM_OFS_LOWHI: next_st.lowLimit[15:8] = regWriteData;
        `LSM_OFS_HIGHLO: next_st.highLimit[7:0] = regWriteData;
        `LSM_OFS_HIGHHI: next_st.highLimit[15:8] = regWriteData;
        `LSM_OFS_FILTER: next_st.filterReg = regWriteData;
        `LSM_OFS_CONFIG: next_st.configReg = regWriteData;
        default: ;
      endcase
    end

    // Phase timing: step length depends on phase and long wait
    if (st.phase == lsm_pkg::PH_WAIT && st.configReg[`LSM_CFG_X12]) begin
      stepTicks = LONG_TICKS;
    end
    if (st.phase != lsm_pkg::PH_IDLE) begin
      if (st.tick + 19'h1 >= stepTicks) begin
        next_st.tick = 19'h0;
        stepDone = 1'b1;
      end else begin
        next_st.tick = st.tick + 19'h1;
      end
    end

    // Measurement cycle sequencer
    case (st.phase)
      lsm_pkg::PH_IDLE: begin
        if (st.enableReg[`LSM_EN_OSC] && st.enableReg[`LSM_EN_MEAS]) begin
          next_st.phase = lsm_pkg::PH_INTEG;
          next_st.tick = 19'h0;
          next_st.steps = 9'h0;
          next_st.measureStart = 1'b1;
        end
      end
      lsm_pkg::PH_INTEG: begin
        if (stepDone) begin
          next_st.steps = st.steps + 9'h1;
          if (st.steps + 9'h1 >= stepCount(st.integReg)) begin
            integEnd = 1'b1;
            next_st.steps = 9'h0;
            if (st.enableReg[`LSM_EN_WAIT]) begin
              next_st.phase = lsm_pkg::PH_WAIT;
            end else begin
              next_st.measureStart = 1'b1;
            end
          end
        end
      end
      lsm_pkg::PH_WAIT: begin
        if (stepDone) begin
          next_st.steps = st.steps + 9'h1;
          if (st.steps + 9'h1 >= stepCount(st.waitReg)) begin
            next_st.steps = 9'h0;
            next_st.phase = lsm_pkg::PH_INTEG;
            next_st.measureStart = 1'b1;
          end
        end
      end
      default: next_st.phase = lsm_pkg::PH_IDLE;
    endcase

    // Window comparator and persistence filter at end of integration
    if (integEnd) begin
      next_st.validFlag = 1'b1;
      outside = (channel0Result < st.lowLimit) || (channel0Result > st.highLimit);
      if (outside) begin
        cnt = (st.outCount == 6'h3f) ? st.outCount : st.outCount + 6'h1;
      end else begin
        cnt = 6'h0;
      end
      next_st.outCount = cnt;
      if (needed == 6'h0) begin
        raiseIrq = 1'b1;
      end else if (outside && cnt >= needed) begin
        raiseIrq = 1'b1;
      end
      raiseIrq = raiseIrq && st.enableReg[`LSM_EN_MASK];
      // Sleep after an interrupting cycle drops the oscillator bit
      if (raiseIrq && st.enableReg[`LSM_EN_SLEEP]) begin
        next_st.enableReg[`LSM_EN_OSC] = 1'b0;
        next_st.phase = lsm_pkg::PH_IDLE;
        next_st.measureStart = 1'b0;
      end
    end

    // Measurement or power off stops the cycle and clears count and valid flag; the interrupt flag is kept
    if (!st.enableReg[`LSM_EN_OSC] || !st.enableReg[`LSM_EN_MEAS]) begin
      next_st.phase = lsm_pkg::PH_IDLE;
      next_st.tick = 19'h0;
      next_st.steps = 9'h0;
      next_st.outCount = 6'h0;
      next_st.measureStart = 1'b0;
      next_st.validFlag = 1'b0;
    end

    // Interrupt flag: clear command, but a new event wins
    if (specialCmd && specialCode == `LSM_CMD_IRQ_CLEAR) begin
      next_st.irqFlag = 1'b0;
    end
    if (raiseIrq) begin
      next_st.irqFlag = 1'b1;
    end
    next_st.intOe = next_st.irqFlag;

    // Read mux, reserved status bits and unmapped addresses read zero
    case (readAddr)
      `LSM_OFS_ENABLE: next_st.readData = next_st.enableReg;
      `LSM_OFS_INTEG: next_st.readData = next_st.integReg;
      `LSM_OFS_WAIT: next_st.readData = next_st.waitReg;
      `LSM_OFS_LOWLO: next_st.readData = next_st.lowLimit[7:0];
      `LSM_OFS_LOWHI: next_st.readData = next_st.lowLimit[15:8];
      `LSM_OFS_HIGHLO: next_st.readData = next_st.highLimit[7:0];
      `LSM_OFS_HIGHHI: next_st.readData = next_st.highLimit[15:8];
      `LSM_OFS_FILTER: next_st.readData = next_st.filterReg;
      `LSM_OFS_CONFIG: next_st.readData = next_st.configReg;
      `LSM_OFS_STATUS: begin
        next_st.readData = 8'h00;
        next_st.readData[`LSM_ST_IRQ] = next_st.irqFlag;
        next_st.readData[`LSM_ST_VALID] = next_st.validFlag;
      end
      default: next_st.readData = 8'h00;
    endcase
  end

  // ****************************************
  // State register
  // ****************************************

  // Synchronous reset to documented values
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st.enableReg <= `LSM_RST_ENABLE;
      st.integReg <= `LSM_RST_INTEG;
      st.waitReg <= `LSM_RST_WAIT;
      st.lowLimit <= {`LSM_RST_LIMIT, `LSM_RST_LIMIT};
      st.highLimit <= {`LSM_RST_LIMIT, `LSM_RST_LIMIT};
      st.filterReg <= `LSM_RST_FILTER;
      st.configReg <= `LSM_RST_CONFIG;
      st.phase <= lsm_pkg::PH_IDLE;
      st.tick <= 19'h0;
      st.steps <= 9'h0;
      st.outCount <= 6'h0;
      st.irqFlag <= 1'b0;
      st.validFlag <= 1'b0;
      st.intOe <= 1'b0;
      st.readData <= 8'h00;
      st.measureStart <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************

  // Straight from state flops, except converterRun decoded from the phase and intOut tied low
  assign regReadData = st.readData;
  assign converterRun = (st.phase == lsm_pkg::PH_INTEG);
  assign measureStart = st.measureStart;
  assign intOut = 1'b0;
  assign intOe = st.intOe;

  // Pin readback not needed inside
  logic unusedIntIn;
  assign unusedIntIn = intIn;

endmodule : lsm_light_measure_control
`default_nettype wire

// ---- lsm_props.sv ----
// Port assertions of the light measure control
`timescale 1ns/1ps
`default_nettype none
module lsm_props (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Host side
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic specialCmd,
  input wire logic [4:0] specialCode,
  input wire logic [7:0] readAddr,
  input wire logic [7:0] regReadData,
  // Converter and pin
  input wire logic converterRun,
  input wire logic measureStart,
  input wire logic intOut,
  input wire logic intOe
);
  logic maskBit;
  logic runOn;
  logic [2:0] sinceRun;
  // Mask shadow and cycles since integration
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      maskBit <= 1'b0;
      runOn <= 1'b0;
      sinceRun <= 3'h7;
    end else begin
      if (regWrite && regAddr == 8'h00) maskBit <= regWriteData[4];
      if (regWrite && regAddr == 8'h00) runOn <= regWriteData[0] && regWriteData[1];
      if (converterRun) sinceRun <= 3'h0;
      else if (sinceRun != 3'h7) sinceRun <= sinceRun + 3'h1;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  chk_pin_low: assert property (intOut == 1'b0)
    else $error("pin driven high");
  chk_start_pulse: assert property (measureStart |=> !measureStart)
    else $error("start not one cycle");
  chk_run_start: assert property ($rose(converterRun) |-> measureStart)
    else $error("run without start");
  chk_run_hold: assert property ($rose(converterRun) |-> (converterRun || !runOn) [*8])
    else $error("integration too short");
  chk_irq_mask: assert property ($rose(intOe) |-> maskBit)
    else $error("irq while masked");
  chk_irq_at_end: assert property ($rose(intOe) |-> sinceRun < 3'h4)
    else $error("irq away from result");
  chk_irq_clear: assert property (specialCmd && specialCode == 5'h06 && sinceRun > 3'h3
    |=> !intOe)
    else $error("clear ignored");
  chk_power_off: assert property (regWrite && regAddr == 8'h00 && !regWriteData[0]
    |-> ##2 !converterRun)
    else $error("runs without power");
  chk_status_bits: assert property (readAddr == 8'h13 |=> (regReadData & 8'hee) == 8'h00)
    else $error("status reserved set");
  // Main scenarios
  cov_irq: cover property ($rose(intOe));
  cov_clear: cover property (specialCmd && intOe);
  cov_end: cover property ($fell(converterRun));
endmodule : lsm_props
bind lsm_light_measure_control lsm_props chk (.clock(clock), .rst_n(rst_n),
  .regWrite(regWrite), .regAddr(regAddr), .regWriteData(regWriteData),
  .specialCmd(specialCmd), .specialCode(specialCode), .readAddr(readAddr),
  .regReadData(regReadData), .converterRun(converterRun),
  .measureStart(measureStart), .intOut(intOut), .intOe(intOe));
`default_nettype wire

// ---- lsm_host.sv ----
// Host model writing registers and issuing commands
`timescale 1ns/1ps
`default_nettype none
module lsm_host (
  // Clock
  input wire logic clock,
  // Register write and command strobes
  output logic regWrite,
  output logic [7:0] regAddr,
  output logic [7:0] regWriteData,
  output logic specialCmd,
  output logic [4:0] specialCode
);
  initial begin
    regWrite = 1'b0;
    regAddr = 8'h00;
    regWriteData = 8'h00;
    specialCmd = 1'b0;
    specialCode = 5'h00;
  end
  // One byte; reserved enable bits sent as zero, bus inverted after
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWriteData <= (a == 8'h00) ? (d & 8'h5b) : d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
    regWriteData <= ~d;
  endtask : wr
  // Interrupt clear command, no data byte
  task automatic clr;
    @(posedge clock);
    specialCode <= 5'h06;
    specialCmd <= 1'b1;
    @(posedge clock);
    specialCmd <= 1'b0;
    specialCode <= 5'h19;
  endtask : clr
endmodule : lsm_host
`default_nettype wire

// ---- test_light_sensor_measure_control.sv ----
// Self-checking bench of the light measure control
`timescale 1ns/1ps
`default_nettype none
module test_light_sensor_measure_control;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] readAddr = 8'h00;
  logic [15:0] channel0Result = 16'h0000;
  logic regWrite, specialCmd, converterRun, measureStart, intOut, intOe;
  logic [7:0] regAddr, regWriteData, regReadData;
  logic [4:0] specialCode;
  integer errors = 0;
  integer nCompared = 0;
  integer seed = 72;
  integer i, n, r;
  logic [7:0] it [3] = '{8'hfe, 8'hff, 8'hff};
  logic [7:0] wt [3] = '{8'hff, 8'hff, 8'hfe};
  logic [7:0] en [3] = '{8'h03, 8'h0b, 8'h0b};
  logic [3:0] codes [4] = '{4'h1, 4'h3, 4'h4, 4'hf};
  always #5 clock = ~clock;
  lsm_host host (.clock(clock), .regWrite(regWrite), .regAddr(regAddr),
    .regWriteData(regWriteData), .specialCmd(specialCmd), .specialCode(specialCode));
  lsm_light_measure_control dut (.clock(clock), .rst_n(rst_n), .regWrite(regWrite),
    .regAddr(regAddr), .regWriteData(regWriteData), .specialCmd(specialCmd),
    .specialCode(specialCode), .readAddr(readAddr), .regReadData(regReadData),
    .channel0Result(channel0Result), .converterRun(converterRun),
    .measureStart(measureStart), .intIn(!intOe), .intOut(intOut), .intOe(intOe));
  // Expected cycle period and filter count
  function automatic integer period(input logic [7:0] a, w, e, c);
    return 273 * (256 - a) + (e[3] ? (256 - w) * (c[1] ? 3276 : 273) : 0);
  endfunction : period
  function automatic integer need(input logic [3:0] c);
    return (c < 4) ? c : (c - 3) * 5;
  endfunction : need
  task automatic check(input string name, input logic [15:0] seen, exp);
    nCompared++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic rdc(input string name, input logic [7:0] a, exp);
    @(posedge clock);
    readAddr <= a;
    @(posedge clock);
    #1 check(name, regReadData, exp);
  endtask : rdc
  // Cycles between two start pulses
  task automatic gap(output integer g);
    g = 0;
    while (measureStart !== 1'b1 && g < 9000) begin
      @(posedge clock);
      #1 g++;
    end
    g = 0;
    do begin
      @(posedge clock);
      #1 g++;
    end while (measureStart !== 1'b1 && g < 9000);
  endtask : gap
  // Start pulses seen until the interrupt rises, the interrupting one included
  task automatic falls(output integer f);
    integer t;
    f = 0;
    t = 0;
    while (intOe !== 1'b1 && t < 20000) begin
      @(posedge clock);
      #1 t++;
      if (measureStart === 1'b1) f++;
    end
  endtask : falls
  task automatic close_out;
    if (errors == 0 && nCompared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  // Watchdog
  initial begin
    repeat (90000) @(posedge clock);
    errors++;
    close_out();
  end
  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    rdc("integ", 8'h01, 8'hff);
    rdc("wait", 8'h03, 8'hff);
    rdc("status", 8'h13, 8'h00);
    for (i = 4; i < 8; i++) begin
      r = $random(seed);
      host.wr(i[7:0], r[7:0]);
      rdc("limit", i[7:0], r[7:0]);
    end
    host.wr(8'h04, 8'h00);
    host.wr(8'h05, 8'h10);
    host.wr(8'h06, 8'h00);
    host.wr(8'h07, 8'h20);
    // Integration, wait and long wait lengths; wait set before enable
    for (i = 0; i < 3; i++) begin
      host.wr(8'h01, it[i]);
      host.wr(8'h03, wt[i]);
      host.wr(8'h0d, {6'h00, i == 2, 1'b0});
      host.wr(8'h00, en[i]);
      gap(n);
      check("period", n, period(it[i], wt[i], en[i], {6'h00, i == 2, 1'b0}));
      host.wr(8'h00, 8'h00);
    end
    host.wr(8'h01, 8'hff);
    // Masked then unmasked, filter code zero
    channel0Result <= 16'h1800;
    host.wr(8'h00, 8'h03);
    repeat (700) @(posedge clock);
    #1 check("masked", intOe, 1'b0);
    host.wr(8'h00, 8'h13);
    falls(n);
    check("every", n, 1);
    rdc("status", 8'h13, 8'h11);
    host.clr();
    #1 check("clear", intOe, 1'b0);
    host.wr(8'h00, 8'h00);
    // Persistence counts with random out-of-range results
    for (i = 0; i < 4; i++) begin
      r = $random(seed);
      channel0Result <= r[0] ? {4'h0, r[12:1]} : {4'h2, r[12:1]} + 16'h0001;
      host.wr(8'h0c, {4'h0, codes[i]});
      host.wr(8'h00, 8'h13);
      falls(n);
      // First start pulse of the run is counted as well
      check("filter", n, need(codes[i]) + 1);
      host.clr();
      host.wr(8'h00, 8'h00);
    end
    // Sleep after interrupt
    host.wr(8'h0c, 8'h00);
    host.wr(8'h00, 8'h53);
    falls(n);
    repeat (5) @(posedge clock);
    rdc("sleep", 8'h00, 8'h52);
    check("run", converterRun, 1'b0);
    host.clr();
    #1 check("sleepclr", intOe, 1'b0);
    repeat (2) @(posedge clock);
    close_out();
  end
endmodule : test_light_sensor_measure_control
`default_nettype wire
